// ===== src/tsa_pkg.sv
// constants, states and field layout of the temperature alarm block
// assumes one core clock of 100 MHz and an asynchronous active-low reset
package tsa_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [1:0]  PTR_TEMP = 2'h0;
  localparam logic [1:0]  PTR_CFG  = 2'h1;
  localparam logic [1:0]  PTR_LOW  = 2'h2;
  localparam logic [1:0]  PTR_HIGH = 2'h3;
  localparam logic [15:0] RST_TEMP = 16'h0000;
  localparam logic [7:0]  RST_CFG  = 8'h00;
  localparam logic [15:0] RST_LOW  = 16'h4b00;
  localparam logic [15:0] RST_HIGH = 16'h5000;
  localparam logic [1:0]  RST_PTR  = 2'h0;
  // configuration upper byte fields, lower byte reads as zero
  localparam int CFG_SD  = 0;
  localparam int CFG_INT = 1;
  localparam int CFG_POL = 2;
  localparam int CFG_FT  = 3;
  localparam int CFG_RES = 5;
  localparam int CFG_OS  = 7;
  localparam logic [7:0]  CFG_LSB  = 8'h00;
  localparam logic [15:0] RES_MASK = 16'h007f;
  // ****************************************************************
  // serial bus codes
  // ****************************************************************
  localparam logic [3:0] ADDR_BASE = 4'h9;
  localparam logic [6:0] ARA_ADDR  = 7'h0c;
  localparam logic [6:0] GC_ADDR   = 7'h00;
  localparam logic [7:0] GC_RESET  = 8'h06;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // ****************************************************************
  // timing and fault queue
  // ****************************************************************
  localparam int CLK_NS   = 10;
  localparam int PULSE_NS = 1000;
  localparam logic [7:0] PULSE_CYC = 8'(PULSE_NS / CLK_NS);
  localparam logic [2:0] FAULT_MAX = 3'h6;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WR   = 7'h08,
    ST_WACK = 7'h10,
    ST_RD   = 7'h20,
    ST_RACK = 7'h40
  } tsa_state_type;
endpackage : tsa_pkg

// ===== src/tsa_sync.sv
// two-stage synchroniser, one stage pair per bit
// assumes inputs are asynchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module tsa_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // data
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  // ****************************************************************
  // per-bit flop pairs, first stage feeds only the second
  // ****************************************************************
  genvar gi;
  for (gi = 0; gi < W; gi++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        meta_q <= 1'b1;
        sync_q <= 1'b1;
      end else begin
        meta_q <= async_in[gi];
        sync_q <= meta_q;
      end
    end
    assign sync_out[gi] = sync_q;
  end
endmodule : tsa_sync
`default_nettype wire

// ===== src/tsa_alarm.sv
// fault queue and alarm state for comparator and interrupt modes
// assumes conversion and control pulses arrive on core_clk
`timescale 1ns/10ps
`default_nettype none
module tsa_alarm (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rstn,
  // conversion result
  input  wire logic                conv,
  input  wire logic                conv_os,
  input  wire logic [15:0]         temp,
  // limits and settings
  input  wire logic [15:0]         lo,
  input  wire logic [15:0]         hi,
  input  wire logic [1:0]          ft,
  input  wire logic                int_mode,
  input  wire logic                sd,
  // clear events
  input  wire logic                clear,
  input  wire logic                gc,
  // alarm, active high
  output var  logic                alarm_o
);
  import tsa_pkg::*;
  logic [2:0] cnt_q, cnt_d, depth;
  logic       kind_q, kind_d, valid_q, valid_d;
  logic       alarm_q, alarm_d, exp_q, exp_d, sd_q;
  logic [7:0] pcnt_q, pcnt_d;
  logic       hi_f, lo_f, sd_in, sd_out, ev, ev_kind, fire;
  // ****************************************************************
  // compare and queue
  // ****************************************************************
  // signed compare so negative limits behave
  assign hi_f   = $signed(temp) >= $signed(hi);
  assign lo_f   = $signed(temp) < $signed(lo);
  assign sd_in  = sd & ~sd_q;
  assign sd_out = ~sd & sd_q;
  always_comb begin
    unique case (ft)
      2'h0: depth = 3'h1;
      2'h1: depth = 3'h2;
      2'h2: depth = 3'h4;
      2'h3: depth = FAULT_MAX;
    endcase
  end
  // next state; a set wins in a clear or sd_in cycle, but gc clears over it
  always_comb begin
    cnt_d   = cnt_q;
    kind_d  = kind_q;
    valid_d = valid_q;
    alarm_d = alarm_q;
    exp_d   = exp_q;
    pcnt_d  = (pcnt_q != 8'h00) ? pcnt_q - 8'h01 : 8'h00;
    fire    = 1'b0;
    if (conv) begin
      if (!hi_f && !lo_f) begin
        cnt_d   = 3'h0;
        valid_d = 1'b0;
      end else begin
        kind_d = hi_f;
        if (kind_q != hi_f || cnt_q == 3'h0)
          cnt_d = 3'h1;
        else if (cnt_q < FAULT_MAX)
          cnt_d = cnt_q + 3'h1;
        valid_d = cnt_d >= depth;
      end
    end
    // shutdown never touches the queue
    ev      = (conv && valid_d) || (sd_out && valid_q);
    ev_kind = conv ? kind_d : kind_q;
    if (int_mode && (clear || sd_in))
      alarm_d = 1'b0;
    if (!int_mode) begin
      if (conv && valid_d)
        alarm_d = kind_d;
    end else if (ev && ev_kind != exp_q) begin
      fire  = 1'b1;
      exp_d = ~exp_q;
      if (conv && conv_os)
        pcnt_d = PULSE_CYC;
      else
        alarm_d = 1'b1;
    end
    if (gc) begin
      alarm_d = 1'b0;
      exp_d   = 1'b0;
      cnt_d   = 3'h0;
      valid_d = 1'b0;
      pcnt_d  = 8'h00;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q   <= 3'h0;
      kind_q  <= 1'b0;
      valid_q <= 1'b0;
      alarm_q <= 1'b0;
      exp_q   <= 1'b0;
      sd_q    <= 1'b0;
      pcnt_q  <= 8'h00;
    end else begin
      cnt_q   <= cnt_d;
      kind_q  <= kind_d;
      valid_q <= valid_d;
      alarm_q <= alarm_d;
      exp_q   <= exp_d;
      sd_q    <= sd;
      pcnt_q  <= pcnt_d;
    end
  end
  assign alarm_o = alarm_q | (pcnt_q != 8'h00);
  // ****************************************************************
  // checks
  // ****************************************************************
  property p_hold;
    @(posedge core_clk) disable iff (!rstn)
    (alarm_q && int_mode && !clear && !sd_in && !gc) |=> alarm_q;
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched alarm dropped without a clear");
  property p_sd_clear;
    @(posedge core_clk) disable iff (!rstn)
    (sd_in && int_mode && !fire) |=> !alarm_q;
  endproperty
  a_sd_clear: assert property (p_sd_clear)
    else $error("shutdown did not clear interrupt alarm");
  property p_gc;
    @(posedge core_clk) disable iff (!rstn)
    gc |=> (!alarm_q && !exp_q && cnt_q == 3'h0);
  endproperty
  a_gc: assert property (p_gc)
    else $error("general call reset left alarm state");
  property p_cmp_stable;
    @(posedge core_clk) disable iff (!rstn)
    (!int_mode && !conv && !gc) |=> $stable(alarm_q);
  endproperty
  a_cmp_stable: assert property (p_cmp_stable)
    else $error("comparator alarm moved without a conversion");
  property p_inrange;
    @(posedge core_clk) disable iff (!rstn)
    (conv && !hi_f && !lo_f && !gc) |=> (cnt_q == 3'h0 && !valid_q);
  endproperty
  a_inrange: assert property (p_inrange)
    else $error("in-range result kept fault count");
  property p_keep_cnt;
    @(posedge core_clk) disable iff (!rstn)
    (!conv && !gc) |=> $stable(cnt_q);
  endproperty
  a_keep_cnt: assert property (p_keep_cnt)
    else $error("fault count changed without a conversion");
  property p_pulse;
    @(posedge core_clk) disable iff (!rstn)
    (fire && conv_os && conv && !gc) |=> alarm_o [*8];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("one-shot alarm pulse too short");
  property p_alt;
    @(posedge core_clk) disable iff (!rstn)
    (fire && !gc) |=> (exp_q != $past(exp_q));
  endproperty
  a_alt: assert property (p_alt)
    else $error("alarm event order did not alternate");
endmodule : tsa_alarm
`default_nettype wire

// ===== src/tsa_top.sv
// two-wire register slave, conversion control and alarm pin
// assumes scl, sda and address straps are asynchronous pins
// assumes the converter runs on core_clk and pulses conv_done
`timescale 1ns/10ps
`default_nettype none
module tsa_top (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // two-wire bus pins
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output var  logic         sda_out,
  output var  logic         sda_oe,
  input  wire logic [2:0]   addr_pins,
  // converter
  output var  logic         conv_start,
  input  wire logic         conv_done,
  input  wire logic [15:0]  conv_result,
  // alarm pin
  output var  logic         alarm_pin
);
  import tsa_pkg::*;
  // ****************************************************************
  // pin synchronisers and edge detect
  // ****************************************************************
  logic [4:0] pins_s;
  logic       scl_s, sda_s, scl_p, sda_p;
  logic       scl_rise, scl_fall, start_c, stop_c;
  logic [2:0] addr_s;
  tsa_sync #(.W(5)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({addr_pins, sda_in, scl_in}),
    .sync_out (pins_s)
  );
  assign scl_s  = pins_s[0];
  assign sda_s  = pins_s[1];
  assign addr_s = pins_s[4:2];
  // previous levels read the second stage only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_c  = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c   = scl_s & scl_p & ~sda_p & sda_s;
  // ****************************************************************
  // state
  // ****************************************************************
  tsa_state_type st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d, msb_q, msb_d;
  logic [1:0]  wb_q, wb_d, ptr_q, ptr_d;
  logic        rw_q, rw_d, ara_q, ara_d, gcm_q, gcm_d;
  logic        fresh_q, fresh_d, lsb_q, lsb_d, oe_q, oe_d;
  logic [7:0]  cfg_q, cfg_d;
  logic [15:0] lo_q, lo_d, hi_q, hi_d, temp_q, temp_d;
  logic        busy_q, busy_d, os_q, os_d, start_q, start_d;
  logic        pin_q, rd_clr, gc_p, alarm, ackw;
  logic [6:0]  own;
  logic [7:0]  rd_byte;
  logic [15:0] rd_word, res_mask;
  assign own = {ADDR_BASE, addr_s};
  // register picked by the pointer, reserved lsb reads zero
  always_comb begin
    unique case (ptr_q)
      PTR_TEMP: rd_word = temp_q;
      PTR_CFG:  rd_word = {cfg_q, CFG_LSB};
      PTR_LOW:  rd_word = lo_q;
      PTR_HIGH: rd_word = hi_q;
    endcase
  end
  assign rd_byte = lsb_q ? rd_word[7:0] : rd_word[15:8];
  // ****************************************************************
  // bus engine
  // ****************************************************************
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    msb_d   = msb_q;
    wb_d    = wb_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    ara_d   = ara_q;
    gcm_d   = gcm_q;
    fresh_d = fresh_q;
    lsb_d   = lsb_q;
    oe_d    = oe_q;
    cfg_d   = cfg_q;
    lo_d    = lo_q;
    hi_d    = hi_q;
    rd_clr  = 1'b0;
    gc_p    = 1'b0;
    ackw    = 1'b1;
    // one-shot bit falls once done; a host write this cycle wins
    if (conv_done && os_q)
      cfg_d[CFG_OS] = 1'b0;
    if (start_c) begin
      st_d    = ST_ADDR;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
      fresh_d = 1'b0;
    end else if (stop_c) begin
      st_d    = ST_IDLE;
      oe_d    = 1'b0;
      fresh_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: ;
        ST_ADDR: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BYTE_BITS) begin
            rw_d  = sh_q[0];
            ara_d = sh_q == {ARA_ADDR, 1'b1} && alarm;
            gcm_d = sh_q == {GC_ADDR, 1'b0};
            if (sh_q[7:1] == own || ara_d || gcm_d) begin
              st_d = ST_AACK;
              oe_d = 1'b1;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              // any read or alert response clears a latch
              rd_clr = 1'b1;
              st_d   = ST_RD;
              sh_d   = ara_q ? {own, 1'b0} : rd_word[15:8];
              lsb_d  = 1'b1;
              oe_d   = ~sh_d[7];
            end else begin
              st_d = ST_WR;
              oe_d = 1'b0;
              wb_d = 2'h0;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == BYTE_BITS) begin
              st_d = ST_RACK;
              oe_d = 1'b0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s) begin
            st_d = ST_IDLE; // master nack ends the read
          end else if (scl_fall) begin
            // pointer kept, so reads repeat the same register
            cnt_d = 4'h0;
            st_d  = ST_RD;
            sh_d  = ara_q ? {own, 1'b0} : rd_byte;
            lsb_d = ~lsb_q;
            oe_d  = ~sh_d[7];
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BYTE_BITS) begin
            if (gcm_q) begin
              gc_p = sh_q == GC_RESET;
            end else if (wb_q == 2'h0) begin
              // reserved pointer bits must be zero
              if (sh_q[7:2] == 6'h00) begin
                ptr_d   = sh_q[1:0];
                fresh_d = 1'b1;
              end
            end else if (fresh_q && ptr_q == PTR_TEMP) begin
              ackw = 1'b0; // read-only target
            end else if (fresh_q && wb_q == 2'h1) begin
              msb_d = sh_q;
              if (ptr_q == PTR_CFG)
                cfg_d = sh_q;
            end else if (fresh_q && wb_q == 2'h2) begin
              if (ptr_q == PTR_LOW)
                lo_d = {msb_q, sh_q};
              else if (ptr_q == PTR_HIGH)
                hi_d = {msb_q, sh_q};
            end
            st_d = ST_WACK;
            oe_d = ackw;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            st_d  = ST_WR;
            oe_d  = 1'b0;
            cnt_d = 4'h0;
            if (wb_q != 2'h3)
              wb_d = wb_q + 2'h1;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    if (gc_p) begin
      cfg_d = RST_CFG;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      msb_q   <= 8'h00;
      wb_q    <= 2'h0;
      ptr_q   <= RST_PTR;
      rw_q    <= 1'b0;
      ara_q   <= 1'b0;
      gcm_q   <= 1'b0;
      fresh_q <= 1'b0;
      lsb_q   <= 1'b0;
      oe_q    <= 1'b0;
      cfg_q   <= RST_CFG;
      lo_q    <= RST_LOW;
      hi_q    <= RST_HIGH;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      msb_q   <= msb_d;
      wb_q    <= wb_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      ara_q   <= ara_d;
      gcm_q   <= gcm_d;
      fresh_q <= fresh_d;
      lsb_q   <= lsb_d;
      oe_q    <= oe_d;
      cfg_q   <= cfg_d;
      lo_q    <= lo_d;
      hi_q    <= hi_d;
    end
  end
  // ****************************************************************
  // conversion control
  // ****************************************************************
  assign res_mask = ~(RES_MASK >> cfg_q[CFG_RES +: 2]);
  // shutdown allows only one pending one-shot conversion
  always_comb begin
    busy_d  = busy_q;
    os_d    = os_q;
    start_d = 1'b0;
    temp_d  = temp_q;
    if (conv_done) begin
      busy_d = 1'b0;
      os_d   = 1'b0;
      // a read in progress keeps showing the old value
      if (!((st_q == ST_RD || st_q == ST_RACK) && ptr_q == PTR_TEMP
            && !ara_q))
        temp_d = conv_result & res_mask;
    end else if (!busy_q && !start_q) begin
      if (!cfg_q[CFG_SD]) begin
        start_d = 1'b1;
        busy_d  = 1'b1;
      end else if (cfg_q[CFG_OS]) begin
        start_d = 1'b1;
        busy_d  = 1'b1;
        os_d    = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_q  <= 1'b0;
      os_q    <= 1'b0;
      start_q <= 1'b0;
      temp_q  <= RST_TEMP;
    end else begin
      busy_q  <= busy_d;
      os_q    <= os_d;
      start_q <= start_d;
      temp_q  <= temp_d;
    end
  end
  // ****************************************************************
  // alarm and pins
  // ****************************************************************
  tsa_alarm u_alarm (
    .core_clk (core_clk),
    .rstn     (rstn),
    .conv     (conv_done),
    .conv_os  (os_q),
    .temp     (conv_result & res_mask),
    .lo       (lo_q),
    .hi       (hi_q),
    .ft       (cfg_q[CFG_FT +: 2]),
    .int_mode (cfg_q[CFG_INT]),
    .sd       (cfg_q[CFG_SD]),
    .clear    (rd_clr),
    .gc       (gc_p),
    .alarm_o  (alarm)
  );
  // pin idles high since polarity resets to active low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      pin_q <= 1'b1;
    else
      pin_q <= cfg_q[CFG_POL] ? alarm : ~alarm;
  end
  assign alarm_pin  = pin_q;
  assign sda_oe     = oe_q;
  assign conv_start = start_q;
  // open-drain data pin only ever pulls low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end
  // ****************************************************************
  // checks
  // ****************************************************************
  property p_bad_ptr;
    @(posedge core_clk) disable iff (!rstn)
    (st_q == ST_WR && scl_fall && cnt_q == BYTE_BITS && !start_c
     && !stop_c && !gcm_q && wb_q == 2'h0 && sh_q[7:2] != 6'h00)
    |=> ($stable(ptr_q) && oe_q);
  endproperty
  a_bad_ptr: assert property (p_bad_ptr)
    else $error("bad pointer changed state or was not acked");
  property p_sd_noconv;
    @(posedge core_clk) disable iff (!rstn)
    (cfg_q[CFG_SD] && !cfg_q[CFG_OS]) |=> !start_q;
  endproperty
  a_sd_noconv: assert property (p_sd_noconv)
    else $error("conversion started during shutdown");
endmodule : tsa_top
`default_nettype wire

// ===== bench/tsa_host.sv
// host model: bit-level two-wire master for the sensor block
// assumes sda is the resolved wire with a pull-up to one
`timescale 1ns/10ps
`default_nettype none
module tsa_host (
  // bus pins
  output var  logic scl,
  output var  logic sda_h,
  input  wire logic sda
);
  // ****
  // link timing
  // ****
  // quarter of the 160 ns link period
  localparam int Q = 40;
  // bus idle: link clock stands still high between frames
  initial begin
    scl   = 1'b1;
    sda_h = 1'b1;
  end
  // ****
  // bus primitives
  // ****
  // one bit: data moves only while scl is low
  task automatic bit1(input logic b, output logic r);
    sda_h = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit1
  task automatic start();
    sda_h = 1'b1;
    #Q scl = 1'b1;
    #Q sda_h = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start
  task automatic stop();
    sda_h = 1'b0;
    #Q scl = 1'b1;
    #Q sda_h = 1'b1;
    #Q;
  endtask : stop
  // byte msb first, a is our ninth bit, k the ninth bit seen
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit1(d[i], r[i]);
    bit1(a, k);
  endtask : xfer
  // register write; pointer resent every time, sent as given
  task automatic wr(input logic [7:0] p, input logic [15:0] v,
                    input int n, output logic k);
    logic [7:0] r;
    start();
    xfer(8'h9a, 1'b1, r, k);
    xfer(p, 1'b1, r, k);
    for (int i = 0; i < n; i++) xfer(v[15-8*i -: 8], 1'b1, r, k);
    stop();
  endtask : wr
  // register read of n bytes, nack on the last one
  task automatic rd(input int n, output logic [15:0] v);
    logic [7:0] r;
    logic       k;
    v = 16'h0000;
    start();
    xfer(8'h9b, 1'b1, r, k);
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i == n - 1, r, k);
      v[15-8*i -: 8] = r;
    end
    stop();
  endtask : rd
endmodule : tsa_host
`default_nettype wire

// ===== bench/tb.sv
// testbench: host model, converter stub and scripted checks
// assumes host model owns the bus, bench owns the converter
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        core_clk, rstn, scl, sda_h, sda_oe, sda_out, done, start;
  logic        alarm_pin, k;
  logic [15:0] res, t_now, v, got;
  logic [7:0]  rnd, dly, b;
  int          n_mismatch, n_compared, n_conv, c0;
  logic [15:0] exp_q[$];
  logic [15:0] rv[4] = '{16'h0000, 16'h0000, 16'h4b00, 16'h5000};
  event        seen;
  // open-drain wire with pull-up, driven level only while enabled
  wire logic   sda = sda_h & (sda_oe ? sda_out : 1'b1);
  tsa_host host (.scl(scl), .sda_h(sda_h), .sda(sda));
  tsa_top uut (.core_clk(core_clk), .rstn(rstn), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_pins(3'h5),
    .conv_start(start), .conv_done(done), .conv_result(res),
    .alarm_pin(alarm_pin));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // converter stub: result 20 cycles after each start
  always @(negedge core_clk) begin
    done <= 1'b0;
    res  <= t_now;
    if (start) begin
      dly    <= 8'h14;
      n_conv <= n_conv + 1;
    end else if (dly != 8'h00) dly <= dly - 8'h01;
    if (!start && dly == 8'h01) done <= 1'b1;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // monitor: each result meets the oldest note
  always @(seen) chk(got, exp_q.pop_front());
  task automatic put(input logic [15:0] e, input logic [15:0] s);
    exp_q.push_back(e);
    got = s;
    -> seen;
    @(negedge core_clk);
  endtask : put
  task automatic rchk(input int n, input logic [15:0] e);
    host.rd(n, v);
    put(e, v);
  endtask : rchk
  // wait covers two conversions, sampled off the edge
  task automatic tchk(input logic [15:0] t, input logic e);
    @(negedge core_clk) t_now = t;
    repeat (60) @(negedge core_clk);
    put({15'h0, e}, {15'h0, alarm_pin});
  endtask : tchk
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // watchdog, far beyond the expected run
  initial begin
    #500000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    rstn = 1'b0;
    t_now = 16'h0000;
    res = 16'h0000;
    done = 1'b0;
    dly = 8'h00;
    n_conv = 0;
    n_mismatch = 0;
    n_compared = 0;
    rnd = 8'h3f;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) rstn = 1'b1;
    repeat (5) @(negedge core_clk);
    // reset values, each read twice on one pointer
    foreach (rv[i]) begin
      host.wr(8'(i), 16'h0, 0, k);
      rchk(2, rv[i]);
      rchk(2, rv[i]);
    end
    // bad pointer is acked but ignored
    host.wr(8'h07, 16'h0, 0, k);
    put(16'h0, {15'h0, k});
    rchk(2, 16'h5000);
    // random lower limit kept below the upper one
    rnd = lfsr(rnd);
    host.wr(8'h02, {8'h20, rnd}, 2, k);
    rchk(2, {8'h20, rnd});
    host.wr(8'h00, 16'h1234, 1, k);
    put(16'h1, {15'h0, k});
    // interrupt mode, queue of one, single config byte
    host.wr(8'h01, 16'h0200, 1, k);
    rchk(2, 16'h0200);
    tchk(16'h0000, 1'b1);
    tchk(16'h6000, 1'b0);
    tchk(16'h4000, 1'b0);
    rchk(2, 16'h0200);
    tchk(16'h4000, 1'b1);
    tchk(16'h6000, 1'b1);
    tchk(16'h0000, 1'b0);
    // shutdown drops the latched alarm and stops conversions
    host.wr(8'h01, 16'h0300, 1, k);
    repeat (40) @(negedge core_clk);
    c0 = n_conv;
    tchk(16'h6000, 1'b1);
    put(16'h0, 16'(n_conv - c0));
    c0 = n_conv;
    host.wr(8'h01, 16'h8300, 1, k);
    repeat (200) @(negedge core_clk);
    put(16'h1, 16'(n_conv - c0));
    // general call reset back to comparator defaults
    host.start();
    host.xfer(8'h00, 1'b1, b, k);
    host.xfer(8'h06, 1'b1, b, k);
    host.stop();
    rchk(2, 16'h0000);
    tchk(16'h6000, 1'b0);
    // comparator shutdown keeps alarm; counter survives to the exit
    host.wr(8'h01, 16'h0100, 1, k);
    tchk(16'h6000, 1'b0);
    host.wr(8'h01, 16'h0300, 1, k);
    tchk(16'h4000, 1'b0);
    rchk(2, 16'h0300);
    host.wr(8'h01, 16'h0200, 1, k);
    tchk(16'h4000, 1'b0);
    // alert response returns own address, repeated, and clears
    host.start();
    host.xfer(8'h19, 1'b1, b, k);
    host.xfer(8'hff, 1'b0, b, k);
    put(16'h009a, {8'h00, b});
    host.xfer(8'hff, 1'b1, b, k);
    put(16'h009a, {8'h00, b});
    host.stop();
    tchk(16'h4000, 1'b1);
    host.wr(8'h01, 16'h0400, 1, k);
    tchk(16'h6000, 1'b1);
    rchk(2, 16'h0400);
    tchk(16'h6000, 1'b1);
    tchk(16'h0000, 1'b0);
    // negative result is a lower fault, not an upper one
    tchk(16'hc900, 1'b0);
    // queue of six: three conversions are not enough
    host.wr(8'h01, 16'h1c00, 1, k);
    tchk(16'h6000, 1'b0);
    repeat (100) @(negedge core_clk);
    tchk(16'h6000, 1'b1);
    finish_test();
  end
endmodule : tb
`default_nettype wire
